// ===== verilog/nvsc_bank.sv
// Shadow control bank with rank-ordered power sequencer
`timescale 1ns/10ps
module nvsc_bank
	import nvsc_pkg::*;
#(
	parameter int STEP_CYC = NVSC_STEP_CYC
) (
	input  wire logic       clk_i,          // 100 MHz clock
	input  wire logic       reset_n_i,      // Sync reset, low
	input  wire logic [7:0] reg_addr_i,     // Register byte address
	input  wire logic       reg_wr_i,       // Write strobe
	input  wire logic       reg_rd_i,       // Read strobe
	input  wire logic [7:0] reg_wdata_i,    // Write data
	output logic      [7:0] reg_rdata_o,    // Read data
	output logic            reg_ack_o,      // Access done
	input  wire logic [1:0] nonvolatile_command_i, // Memory command
	output logic            nvm_wr_o,       // Store strobe
	output logic     [23:0] nvm_wdata_o,    // Bytes to store
	input  wire logic [23:0] nvm_rdata_i,   // Stored bytes
	input  wire logic       supply_rise_i,  // Supply rise pin
	input  wire logic       usb_bus_voltage_detected_i, // USB pin
	input  wire logic       key_turn_on_i,  // Other turn-on pin
	input  wire logic       long_key_press_i, // Long press pin
	input  wire logic       overcurrent_i,  // Any regulator overcurrent
	input  wire logic [7:0] per_regulator_overcurrent_shutdown_en_i, // En
	input  wire logic [7:0] oc_source_i,    // Which regulators trip
	input  wire logic       overcurrent_lock_clr_i, // Clears lock flag
	output logic            overcurrent_lock_flag_o, // Lock flag
	output logic      [7:0] reg_en_o,       // Bucks A-D, linears A-D
	output logic      [1:0] supply_good_hysteresis_code_o, // Hys code
	output logic      [1:0] supply_good_rise_threshold_code_o, // Thr code
	output logic            powered_o       // Sequencer is on
);
	// Step timer needs at least one cycle per rank, refused at build
	if (STEP_CYC < 1) begin : g_bad_step
		$error("STEP_CYC below one");
	end

	logic [7:0] main_q, buck_q, lin_q;
	nvsc_main_t mc;
	assign mc = nvsc_main_t'(main_q);

	////////////////////////////////////////////////////////////////
	// Pin synchronisers: first stage feeds only the second
	logic [4:0] s1_q, s2_q, s3_q;
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			s1_q <= 5'h0_0;
			s2_q <= 5'h0_0;
			s3_q <= 5'h0_0;
		end else begin
			s1_q <= {supply_rise_i, usb_bus_voltage_detected_i,
				key_turn_on_i, long_key_press_i, overcurrent_i};
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end
	logic rise_ev, usb_ev, key_ev, lkp_ev, oc_lvl;
	assign rise_ev = s2_q[4] & ~s3_q[4];
	assign usb_ev  = s2_q[3] & ~s3_q[3];
	assign key_ev  = s2_q[2] & ~s3_q[2];
	assign lkp_ev  = s2_q[1] & ~s3_q[1];
	assign oc_lvl  = s2_q[0];

	////////////////////////////////////////////////////////////////
	// Register writes and memory reload
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			main_q <= NVSC_MAIN_RST;
			buck_q <= NVSC_BUCK_RST;
			lin_q  <= NVSC_LIN_RST;
		end else if (nonvolatile_command_i == NVSC_CMD_RELOAD) begin
			{lin_q, buck_q, main_q} <= nvm_rdata_i;
		end else if (reg_wr_i) begin
			if (reg_addr_i == NVSC_OFS_MAIN)
				main_q <= reg_wdata_i;
			if (reg_addr_i == NVSC_OFS_BUCK)
				buck_q <= reg_wdata_i;
			if (reg_addr_i == NVSC_OFS_LIN)
				lin_q <= reg_wdata_i;
		end
	end

	// Read data registered; unmapped addresses read zero
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			reg_rdata_o <= 8'h00;
			reg_ack_o   <= 1'b0;
		end else begin
			reg_ack_o <= reg_wr_i | reg_rd_i;
			unique case (reg_addr_i)
				NVSC_OFS_MAIN: reg_rdata_o <= main_q;
				NVSC_OFS_BUCK: reg_rdata_o <= buck_q;
				NVSC_OFS_LIN:  reg_rdata_o <= lin_q;
				default:       reg_rdata_o <= 8'h00;
			endcase
		end
	end

	// store strobe one cycle per command cycle
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			nvm_wr_o    <= 1'b0;
			nvm_wdata_o <= 24'h00_0000;
		end else begin
			nvm_wr_o    <= nonvolatile_command_i == NVSC_CMD_STORE;
			nvm_wdata_o <= {lin_q, buck_q, main_q};
		end
	end

	////////////////////////////////////////////////////////////////
	// Supply-good codes driven to the analog comparator
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			supply_good_hysteresis_code_o     <= 2'h0;
			supply_good_rise_threshold_code_o <= 2'h0;
		end else begin
			supply_good_hysteresis_code_o <= mc.hys;
			supply_good_rise_threshold_code_o <= mc.thr;
		end
	end

	////////////////////////////////////////////////////////////////
	// Rank of each regulator, bucks in slots 0-3, linears 4-7
	logic [1:0] rank [NVSC_NREG];
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_rank
			assign rank[g]     = buck_q[2*g +: 2];
			assign rank[g + 4] = lin_q[2*g +: 2];
		end
	endgenerate

	// Overcurrent decision
	logic oc_trip;
	always_comb begin
		// latched mode trips on any short
		if (mc.latched_overcurrent_shutdown)
			oc_trip = oc_lvl;
		else
			oc_trip = oc_lvl & |(oc_source_i &
				per_regulator_overcurrent_shutdown_en_i);
	end

	// lock flag, set wins over clear
	always_ff @(posedge clk_i) begin
		if (!reset_n_i)
			overcurrent_lock_flag_o <= 1'b0;
		else if (oc_trip && mc.latched_overcurrent_shutdown)
			overcurrent_lock_flag_o <= 1'b1;
		else if (overcurrent_lock_clr_i)
			overcurrent_lock_flag_o <= 1'b0;
	end

	////////////////////////////////////////////////////////////////
	// Sequencer: one step per rank every STEP_CYC cycles
	nvsc_state_t st_q;
	logic [1:0]  step_q;
	logic [31:0] tmr_q;
	logic        usb_on_q;
	logic        tick, turn_on, turn_off;
	assign tick = tmr_q == 32'(STEP_CYC - 1);
	// supply rise counts only with auto start
	assign turn_on = !overcurrent_lock_flag_o && (usb_ev || key_ev ||
		(rise_ev && mc.auto_start));
	// long press off only when enabled
	assign turn_off = oc_trip ||
		(lkp_ev && mc.long_key_press_shutdown_en);

	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			st_q     <= NVSC_OFF;
			step_q   <= 2'h0;
			tmr_q    <= 32'h0000_0000;
			usb_on_q <= 1'b0;
		end else begin
			tmr_q <= tick ? 32'h0000_0000 : tmr_q + 32'h0000_0001;
			unique case (st_q)
				NVSC_OFF: if (turn_on) begin
					st_q     <= NVSC_UP;
					step_q   <= 2'h0;
					tmr_q    <= 32'h0000_0000;
					usb_on_q <= usb_ev;
				end
				NVSC_UP: if (turn_off) begin
					st_q <= NVSC_DOWN;
				end else if (tick) begin
					if (step_q == 2'h3)
						st_q <= NVSC_ON;
					else
						step_q <= step_q + 2'h1;
				end
				NVSC_ON: if (turn_off)
					st_q <= NVSC_DOWN;
				NVSC_DOWN: if (tick) begin
					if (step_q == 2'h0)
						st_q <= NVSC_OFF;
					else
						step_q <= step_q - 2'h1;
				end
			endcase
		end
	end

	// Enables follow the current step; shared ranks switch together
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			reg_en_o <= 8'h00;
		end else begin
			for (int i = 0; i < NVSC_NREG; i++) begin
				reg_en_o[i] <= (st_q == NVSC_ON) ||
					(st_q != NVSC_OFF && rank[i] <= step_q);
			end
			// linear D needs a USB-caused turn-on unless usb_ldo_always_start is set
			if (!mc.usb_ldo_always_start && !usb_on_q)
				reg_en_o[7] <= 1'b0;
		end
	end

	assign powered_o = st_q == NVSC_ON;
endmodule

// ===== verilog/nvsc_pkg.sv
// Constants and types for the shadow control bank and power sequencer
// Contract
// - Main control bits 7:6 hold supply-good hysteresis code, 200 to 500 mV.
// - Main control bits 5:4 hold supply-good rise threshold code, 3.1-4.0 V.
// - Bit 3 clear: linear D starts only when USB bus voltage caused turn-on.
// - Bit 3 set: linear D starts at its rank on every turn-on.
// - Long key press turns device off only when bit 2 set.
// - Supply rise starts power-up automatically only when bit 1 set.
// - Bit 0 clear: overcurrent shuts down only if regulator's enable bit set.
// - Bit 0 set: short circuit shuts down and locks off until flag reset.
// - Buck rank byte: four 2-bit ranks, buck D high to buck A low.
// - Linear rank byte: four 2-bit ranks, linear D high to linear A low.
// - Main control byte fully read/write; reset value is part default.
// - Command 01 stores shadows to memory, 10 reloads them, others idle.
package nvsc_pkg;
	localparam logic [7:0] NVSC_OFS_MAIN = 8'hf8;
	localparam logic [7:0] NVSC_OFS_BUCK = 8'hf9;
	localparam logic [7:0] NVSC_OFS_LIN  = 8'hfa;
	localparam int NVSC_HYS_LSB   = 6;
	localparam int NVSC_THR_LSB   = 4;
	localparam int NVSC_USBLDO    = 3;
	localparam int NVSC_LKP       = 2;
	localparam int NVSC_AUTO      = 1;
	localparam int NVSC_LOCK      = 0;
	localparam logic [1:0] NVSC_CMD_STORE  = 2'h1;
	localparam logic [1:0] NVSC_CMD_RELOAD = 2'h2;
	localparam logic [7:0] NVSC_MAIN_RST = 8'hee;
	localparam logic [7:0] NVSC_BUCK_RST = 8'h92;
	localparam logic [7:0] NVSC_LIN_RST  = 8'hc0;
	// Rank step time of the sequencer
	localparam int NVSC_STEP_US   = 1;
	localparam int NVSC_CLK_MHZ   = 100;
	localparam int NVSC_STEP_CYC  = NVSC_STEP_US * NVSC_CLK_MHZ;
	localparam int NVSC_NREG      = 8;
	typedef struct packed {
		logic [1:0] hys;
		logic [1:0] thr;
		logic       usb_ldo_always_start;
		logic       long_key_press_shutdown_en;
		logic       auto_start;
		logic       latched_overcurrent_shutdown;
	} nvsc_main_t;
	typedef enum logic [3:0] {
		NVSC_OFF  = 4'b0001,
		NVSC_UP   = 4'b0010,
		NVSC_ON   = 4'b0100,
		NVSC_DOWN = 4'b1000
	} nvsc_state_t;
endpackage

// ===== sim/nvsc_bank_checker.sv
// Port assertions for the shadow control bank
`timescale 1ns/10ps
module nvsc_bank_checker
	import nvsc_pkg::*;
#(parameter int STEP_CYC = NVSC_STEP_CYC) (
	input wire logic       clk_i,                   // Clock
	input wire logic       reset_n_i,               // Reset
	input wire logic [7:0] reg_addr_i,              // Addr
	input wire logic       reg_wr_i,                // Write
	input wire logic       reg_rd_i,                // Read
	input wire logic [7:0] reg_wdata_i,             // Wdata
	input wire logic [7:0] reg_rdata_o,             // Rdata
	input wire logic       reg_ack_o,               // Ack
	input wire logic [1:0] nonvolatile_command_i,   // Cmd
	input wire logic       nvm_wr_o,                // Store
	input wire logic       overcurrent_lock_clr_i,  // Clr
	input wire logic       overcurrent_lock_flag_o, // Flag
	input wire logic [7:0] reg_en_o,                // Enables
	input wire logic [1:0] supply_good_hysteresis_code_o,     // Hys
	input wire logic [1:0] supply_good_rise_threshold_code_o, // Thr
	input wire logic       powered_o                // On
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	// Codes lag the write by two edges: shadow byte, then output flops
	sequence main_wr_s;
		reg_wr_i && reg_addr_i == NVSC_OFS_MAIN
		&& nonvolatile_command_i != NVSC_CMD_RELOAD;
	endsequence
	ack_pulse_a: assert property ((reg_wr_i || reg_rd_i) |=> reg_ack_o)
		else $error("no ack");
	ack_idle_a: assert property (!(reg_wr_i || reg_rd_i) |=> !reg_ack_o)
		else $error("stray ack");
	unmapped_zero_a: assert property (reg_rd_i && (reg_addr_i < 8'hf8
		|| reg_addr_i > 8'hfa) |=> reg_rdata_o == 8'h00) else $error("unmapped");
	main_codes_a: assert property (main_wr_s |-> ##2
		{supply_good_hysteresis_code_o, supply_good_rise_threshold_code_o,
		4'h0} == ($past(reg_wdata_i, 2) & 8'hf0)) else $error("codes");
	store_pulse_a: assert property (nonvolatile_command_i == 2'h1
		|=> nvm_wr_o) else $error("no store");
	store_only_a: assert property (nonvolatile_command_i != 2'h1
		|=> !nvm_wr_o) else $error("stray store");
	lock_hold_a: assert property (overcurrent_lock_flag_o
		&& !overcurrent_lock_clr_i |=> overcurrent_lock_flag_o) else $error("lock");
	locked_off_a: assert property (overcurrent_lock_flag_o && !powered_o
		|=> !powered_o) else $error("locked on");
	rank_on_a: assert property (powered_o |=> reg_en_o[6:0] == 7'h7f)
		else $error("ranks");
endmodule
bind nvsc_bank nvsc_bank_checker #(.STEP_CYC(STEP_CYC)) nvsc_bank_checker_i (
	.clk_i, .reset_n_i, .reg_addr_i, .reg_wr_i, .reg_rd_i, .reg_wdata_i,
	.reg_rdata_o, .reg_ack_o, .nonvolatile_command_i, .nvm_wr_o,
	.overcurrent_lock_clr_i, .overcurrent_lock_flag_o, .reg_en_o,
	.supply_good_hysteresis_code_o, .supply_good_rise_threshold_code_o,
	.powered_o);

// ===== sim/nvsc_nvm.sv
// Behavioural memory behind the store and reload port
`timescale 1ns/10ps
module nvsc_nvm (
	input  wire logic        clk_i,   // Clock
	input  wire logic        wr_i,    // Store strobe
	input  wire logic [23:0] wdata_i, // Bytes in
	output logic      [23:0] rdata_o  // Bytes kept
);
	always @(posedge clk_i) if (wr_i) rdata_o <= wdata_i;
	initial rdata_o = 24'h00_0000;
endmodule

// ===== sim/test_nvsc_bank.sv
// Self-checking bench for the shadow control bank
`timescale 1ns/10ps
module test_nvsc_bank;
	import nvsc_pkg::*;
	logic        clk_i = 0, reset_n_i = 0, reg_wr_i = 0, reg_rd_i = 0;
	logic        overcurrent_lock_clr_i = 0, reg_ack_o, nvm_wr_o, powered_o;
	logic        overcurrent_lock_flag_o;
	logic [7:0]  reg_addr_i = 0, reg_wdata_i = 0, reg_rdata_o, reg_en_o;
	logic [7:0]  en_m = 0, oc_s = 0, e[3];
	logic [1:0]  nonvolatile_command_i = 0, hys, thr;
	logic [4:0]  pins = 0;
	logic [23:0] nvm_wdata_o, nvm_rdata_i;
	logic [8:0]  q[$], n;
	int          errors = 0, checked = 0, seed = 93;
	always #5 clk_i = ~clk_i;
	nvsc_bank #(.STEP_CYC(2)) nvsc_bank_i (.clk_i, .reset_n_i, .reg_addr_i,
		.reg_wr_i, .reg_rd_i, .reg_wdata_i, .reg_rdata_o, .reg_ack_o,
		.nonvolatile_command_i, .nvm_wr_o, .nvm_wdata_o, .nvm_rdata_i,
		.supply_rise_i(pins[0]), .usb_bus_voltage_detected_i(pins[1]),
		.key_turn_on_i(pins[2]), .long_key_press_i(pins[3]),
		.overcurrent_i(pins[4]), .oc_source_i(oc_s),
		.per_regulator_overcurrent_shutdown_en_i(en_m),
		.overcurrent_lock_clr_i, .overcurrent_lock_flag_o, .reg_en_o,
		.supply_good_hysteresis_code_o(hys), .powered_o,
		.supply_good_rise_threshold_code_o(thr));
	nvsc_nvm nvsc_nvm_i (.clk_i, .wr_i(nvm_wr_o), .wdata_i(nvm_wdata_o),
		.rdata_o(nvm_rdata_i));
	////////////////////////////////////////////////////////////////////////
	task chk(input logic [8:0] s, x);
		checked++;
		if (s !== x) begin
			errors++;
			$display("[FAIL] %0t seen %h expected %h", $time, s, x);
		end
	endtask
	task end_of_test;
		if (errors == 0 && checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// One-cycle strobe, as the bank takes every cycle it is high
	task acc(input logic r, input logic [7:0] a, d);
		@(posedge clk_i);
		reg_rd_i <= r;
		reg_wr_i <= !r;
		reg_addr_i <= a;
		reg_wdata_i <= d;
		q.push_back({r, d});
		@(posedge clk_i);
		reg_rd_i <= 0;
		reg_wr_i <= 0;
	endtask
	task all3(input logic r, input logic [7:0] m);
		for (int i = 0; i < 3; i++) acc(r, 8'(8'hf8 + i), e[i] ^ m);
	endtask
	task cmd(input logic [1:0] c);
		@(posedge clk_i);
		nonvolatile_command_i <= c;
		@(posedge clk_i);
		nonvolatile_command_i <= 0;
	endtask
	// Pins pass a synchroniser, so hold a few cycles and let steps finish
	task pin(input int k);
		@(posedge clk_i);
		pins[k] <= 1;
		repeat (3) @(posedge clk_i);
		pins[k] <= 0;
		repeat (24) @(posedge clk_i);
	endtask
	// Read results meet their notes in order
	always @(posedge clk_i) begin
		if (reg_ack_o === 1'b1) begin
			n = q.pop_front();
			if (n[8]) chk({1'b0, reg_rdata_o}, {1'b0, n[7:0]});
		end
	end
	initial begin
		repeat (5000) @(posedge clk_i);
		errors++;
		end_of_test;
	end
	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (20) @(posedge clk_i);
		reset_n_i <= 1;
		e = '{NVSC_MAIN_RST, NVSC_BUCK_RST, NVSC_LIN_RST};
		all3(1, 8'h00);
		chk({5'h00, hys, thr}, {5'h00, NVSC_MAIN_RST[7:4]});
		acc(1, 8'hfb, 8'h00);
		for (int i = 0; i < 3; i++) e[i] = 8'($random(seed));
		all3(0, 8'h00);
		cmd(2'h1);
		all3(0, 8'hff);
		cmd(2'h3);
		all3(1, 8'hff);
		cmd(2'h2);
		all3(1, 8'h00);
		chk({5'h00, hys, thr}, {5'h00, e[0][7:4]});
		acc(0, 8'hf9, 8'he4);
		acc(0, 8'hfa, 8'he4);
		acc(0, 8'hf8, 8'h00);
		pin(0);
		chk({powered_o, reg_en_o}, 9'h000);
		acc(0, 8'hf8, 8'h02);
		pin(0);
		pin(3);
		chk({powered_o, reg_en_o}, 9'h17f);
		acc(0, 8'hf8, 8'h06);
		pin(3);
		chk({powered_o, reg_en_o}, 9'h000);
		acc(0, 8'hf8, 8'h09);
		// First enables seen must be the rank-zero slots only
		@(posedge clk_i);
		pins[2] <= 1;
		while (reg_en_o === 8'h00) @(posedge clk_i);
		chk({1'b0, reg_en_o}, 9'h011);
		pins[2] <= 0;
		repeat (24) @(posedge clk_i);
		chk({powered_o, reg_en_o}, 9'h1ff);
		pin(4);
		pin(2);
		chk({overcurrent_lock_flag_o, reg_en_o}, 9'h100);
		overcurrent_lock_clr_i <= 1;
		acc(0, 8'hf8, 8'h08);
		overcurrent_lock_clr_i <= 0;
		oc_s <= 8'h01;
		pin(2);
		pin(4);
		chk({overcurrent_lock_flag_o, reg_en_o}, 9'h0ff);
		en_m <= 8'h01;
		pin(4);
		chk({powered_o, reg_en_o}, 9'h000);
		end_of_test;
	end
endmodule
